// file: pkg/srcfg_params.svh
/*
 * constants of the sample rate configuration block: register indices,
 * field positions, reset values, power and mode codes, unlock sequence values.
 * assumes: included by bare name from the package and the design files.
 */
`ifndef SRCFG_PARAMS_SVH
`define SRCFG_PARAMS_SVH

// ----------------------------------------------------------------
// register indices and reset byte; byte address is four times the index
// ----------------------------------------------------------------
`define SRCFG_IDX_MODE 8'h10
`define SRCFG_IDX_WAKE 8'h11
`define SRCFG_IDX_ACT 8'h12
`define SRCFG_IDX_PWR 8'h1c
`define SRCFG_IDX_AUX 8'h29
`define SRCFG_IDX_STAT 8'h30
`define SRCFG_IDX_ODR 8'h31
`define SRCFG_RST_BYTE 8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SRCFG_F_CODE 3:0
`define SRCFG_F_PTR 7:4
`define SRCFG_F_STBY 7:5
`define SRCFG_B_ACT_RSV 4
`define SRCFG_F_PM_WAKE 2:0
`define SRCFG_F_PM_ACT 6:4
`define SRCFG_F_MODE 2:0

// ----------------------------------------------------------------
// power modes and operating modes
// ----------------------------------------------------------------
`define SRCFG_PM_ULP 3'h3
`define SRCFG_PM_LP 3'h0
`define SRCFG_PM_PREC 3'h4
`define SRCFG_MODE_STANDBY 3'h1
`define SRCFG_MODE_CONTINUOUS_WAKE 3'h5

// ----------------------------------------------------------------
// rate 15 unlock sequence
// ----------------------------------------------------------------
`define SRCFG_RATE15 8'h0f
`define SRCFG_PTR1 8'h10
`define SRCFG_SET1 8'h03
`define SRCFG_PTR2 8'h20
`define SRCFG_SET2 8'h01
`define SRCFG_PTR3 8'h40
`define SRCFG_PTR4 8'h50
`define SRCFG_V1_ULP 8'h52
`define SRCFG_V1_LP 8'h72
`define SRCFG_V1_PREC 8'h32
`define SRCFG_V2_ULP 8'h01
`define SRCFG_V2_LP 8'h02
`define SRCFG_V2_PREC 8'h12
`endif

// file: pkg/srcfg_pkg.sv
/*
 * types of the sample rate configuration block.
 * assumes: nothing beyond the params header.
 */
`default_nettype none
`include "srcfg_params.svh"
package srcfg_pkg;
   // rate in tenths of a hertz; ok low means unsupported
   typedef struct packed {
      logic ok;
      logic [15:0] odr;
   } srcfg_rate_t;

   // latched address phase
   typedef struct packed {
      logic wr;
      logic [31:0] addr;
   } srcfg_req_t;

   typedef enum logic [3:0] {
      SQ_IDLE, SQ_PTR1, SQ_SET1, SQ_PTR2, SQ_SET2,
      SQ_PTR3, SQ_VAL1, SQ_PTR4, SQ_ARMED
   } srcfg_seq_t;
endpackage
`default_nettype wire

// file: src/srcfg_odr_lut.sv
/*
 * rate lookup: maps a rate code and power mode to an output data rate.
 * assumes: combinational use, result registered by the caller.
 */
`timescale 1ns/10ps
`default_nettype none
`include "srcfg_params.svh"
module srcfg_odr_lut #(
   parameter int IS_ACT = 0
) (
   // selection
   input wire logic [3:0] code,
   input wire logic [2:0] pmode,
   // result
   output var srcfg_pkg::srcfg_rate_t rate
);
   logic [47:0] row;
   logic [15:0] odr;

   if (IS_ACT < 0 || IS_ACT > 1) begin : g_chk
      $error("srcfg_odr_lut: IS_ACT must be 0 or 1");
   end

   // row is {ultra_low_power, low_power, precision}, zero marks n/a
   always_comb begin
      row = 48'h0;
      if (IS_ACT != 0) begin
         case (code)
            4'h0: row = {16'h003c, 16'h0046, 16'h0046};
            4'h1: row = {16'h0004, 16'h0004, 16'h0002};
            4'h2: row = {16'h0008, 16'h0008, 16'h0004};
            4'h3: row = {16'h000f, 16'h000f, 16'h0009};
            4'h4: row = {16'h003c, 16'h0046, 16'h0046};
            4'h5: row = {16'h0082, 16'h008c, 16'h008c};
            4'h6: row = {16'h00fa, 16'h0118, 16'h0118};
            4'h7: row = {16'h01f4, 16'h021c, 16'h0226};
            4'h8: row = {16'h03e8, 16'h041a, 16'h0320};
            4'h9: row = {16'h076c, 16'h0834, 16'h0000};
            4'ha: row = {16'h0ed8, 16'h0fa0, 16'h0000};
            4'hb: row = {16'h1d4c, 16'h1770, 16'h0000};
            default: row = 48'h0;
         endcase
      end else begin
         case (code)
            4'h5: row = {16'h0000, 16'h008c, 16'h008c};
            4'h6: row = {16'h00fa, 16'h0118, 16'h0118};
            4'h7: row = {16'h01f4, 16'h021c, 16'h0226};
            4'h8: row = {16'h03e8, 16'h041a, 16'h0320};
            4'h9: row = {16'h076c, 16'h0834, 16'h0000};
            4'ha: row = {16'h0ed8, 16'h0fa0, 16'h0000};
            4'hb: row = {16'h1d4c, 16'h1770, 16'h0000};
            4'hc: row = {16'h2af8, 16'h0000, 16'h0000};
            4'hf: row = {16'h32c8, 16'h1d4c, 16'h03e8};
            default: row = 48'h0;
         endcase
      end
   end

   always_comb begin
      case (pmode)
         `SRCFG_PM_ULP: odr = row[47:32];
         `SRCFG_PM_LP: odr = row[31:16];
         `SRCFG_PM_PREC: odr = row[15:0];
         default: odr = 16'h0;
      endcase
      rate.odr = odr;
      rate.ok = |odr;
   end
endmodule // srcfg_odr_lut
`default_nettype wire

// file: src/srcfg_sample_rate_config.sv
/*
 * sample rate configuration: wake rate, activity rate, power mode and mode
 * registers behind an AHB-Lite slave, rate 15 unlock tracking, and the
 * effective data rates that result.
 * assumes: one AHB-Lite master, single word transfers, HREADY is HREADYOUT.
 */
`timescale 1ns/10ps
`default_nettype none
`include "srcfg_params.svh"
module srcfg_sample_rate_config (
   // clock and reset
   input wire logic REF_CLK,
   input wire logic RSTN,
   // AHB-Lite slave
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   // effective rates, tenths of a hertz, and standby clock code
   output logic [15:0] WAKE_ODR,
   output logic WAKE_ODR_OK,
   output logic [15:0] ACT_ODR,
   output logic ACT_ODR_OK,
   output logic [2:0] STBY_CLK_CODE,
   // operating state
   output logic CONT_WAKE,
   output logic STANDBY,
   output logic RATE15_UNLOCKED
);
   logic take;
   logic wr_pend_r, rd_pend_r, hready_r, hresp_r;
   logic [31:0] hrdata_r, rd_mux;
   srcfg_pkg::srcfg_req_t req_r;
   logic [7:0] wd;
   logic wr_mode, wr_wake, wr_act, wr_pwr, wr_aux;
   logic [7:0] mode_r, pwr_r, aux_r;
   logic [3:0] wake_code_r, act_code_r;
   logic [2:0] act_stby_r;
   logic unlock_r;
   srcfg_pkg::srcfg_seq_t seq_r;
   srcfg_pkg::srcfg_rate_t wake_lut, act_lut;
   logic wake_ok;
   logic [15:0] wake_odr_r, act_odr_r;
   logic wake_ok_r, act_ok_r, continuous_wake_r, stby_r;
   logic [2:0] stby_clk_r;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   function automatic logic hit(input logic [31:0] a, input logic [7:0] idx);
      hit = (a[31:10] == 22'h0) && (a[9:2] == idx) && (a[1:0] == 2'b00);
   endfunction

   function automatic logic pm_ok(input logic [2:0] p);
      pm_ok = (p == `SRCFG_PM_ULP) || (p == `SRCFG_PM_LP) || (p == `SRCFG_PM_PREC);
   endfunction

   function automatic logic [7:0] val1(input logic [2:0] p);
      case (p)
         `SRCFG_PM_ULP: val1 = `SRCFG_V1_ULP;
         `SRCFG_PM_LP: val1 = `SRCFG_V1_LP;
         default: val1 = `SRCFG_V1_PREC;
      endcase
   endfunction

   function automatic logic [7:0] val2(input logic [2:0] p);
      case (p)
         `SRCFG_PM_ULP: val2 = `SRCFG_V2_ULP;
         `SRCFG_PM_LP: val2 = `SRCFG_V2_LP;
         default: val2 = `SRCFG_V2_PREC;
      endcase
   endfunction

   // ----------------------------------------------------------------
   // bus slave: writes zero wait, reads one wait state
   // ----------------------------------------------------------------
   assign take = HSEL && HTRANS[1] && HREADY;
   assign wd = HWDATA[7:0];
   assign wr_mode = wr_pend_r && hit(req_r.addr, `SRCFG_IDX_MODE);
   assign wr_wake = wr_pend_r && hit(req_r.addr, `SRCFG_IDX_WAKE);
   assign wr_act = wr_pend_r && hit(req_r.addr, `SRCFG_IDX_ACT);
   assign wr_pwr = wr_pend_r && hit(req_r.addr, `SRCFG_IDX_PWR);
   assign wr_aux = wr_pend_r && hit(req_r.addr, `SRCFG_IDX_AUX);

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wr_pend_r <= 1'b0;
         rd_pend_r <= 1'b0;
         req_r <= '0;
      end else begin
         wr_pend_r <= take && HWRITE;
         rd_pend_r <= take && !HWRITE;
         if (take) begin
            req_r <= '{wr: HWRITE, addr: HADDR};
         end
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         hready_r <= 1'b1;
         hresp_r <= 1'b0;
         hrdata_r <= 32'h0;
      end else begin
         hready_r <= !(take && !HWRITE);
         hresp_r <= 1'b0;
         if (rd_pend_r) begin
            hrdata_r <= rd_mux;
         end
      end
   end

   // unmapped addresses read zero
   always_comb begin
      rd_mux = 32'h0;
      if (hit(req_r.addr, `SRCFG_IDX_MODE)) begin
         rd_mux = {24'h0, mode_r};
      end else if (hit(req_r.addr, `SRCFG_IDX_WAKE)) begin
         rd_mux = {28'h0, wake_code_r};
      end else if (hit(req_r.addr, `SRCFG_IDX_ACT)) begin
         rd_mux = {24'h0, act_stby_r, 1'b0, act_code_r};
      end else if (hit(req_r.addr, `SRCFG_IDX_PWR)) begin
         rd_mux = {24'h0, pwr_r};
      end else if (hit(req_r.addr, `SRCFG_IDX_AUX)) begin
         rd_mux = {24'h0, aux_r};
      end else if (hit(req_r.addr, `SRCFG_IDX_STAT)) begin
         rd_mux = {24'h0, 4'h0, seq_r == srcfg_pkg::SQ_ARMED, unlock_r, act_ok_r, wake_ok_r};
      end else if (hit(req_r.addr, `SRCFG_IDX_ODR)) begin
         rd_mux = {act_odr_r, wake_odr_r};
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         mode_r <= `SRCFG_RST_BYTE;
         pwr_r <= `SRCFG_RST_BYTE;
         aux_r <= `SRCFG_RST_BYTE;
      end else begin
         if (wr_mode) mode_r <= wd;
         if (wr_pwr) pwr_r <= wd;
         if (wr_aux) aux_r <= wd;
      end
   end

   // pointer writes (upper nibble set) leave the code alone; any code accepted
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wake_code_r <= 4'h0;
      end else if (wr_wake && wd[`SRCFG_F_PTR] == 4'h0) begin
         wake_code_r <= wd[`SRCFG_F_CODE];
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         act_code_r <= 4'h0;
         act_stby_r <= 3'h0;
      end else if (wr_act) begin
         act_code_r <= wd[`SRCFG_F_CODE];
         act_stby_r <= wd[`SRCFG_F_STBY];
      end
   end

   // ----------------------------------------------------------------
   // rate 15 unlock tracking
   // ----------------------------------------------------------------
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         seq_r <= srcfg_pkg::SQ_IDLE;
      end else if (wr_wake) begin
         if (wd[`SRCFG_F_PTR] == 4'h0) begin
            seq_r <= srcfg_pkg::SQ_IDLE;
         end else begin
            case (seq_r)
               srcfg_pkg::SQ_SET1:
                  seq_r <= (wd == `SRCFG_PTR2) ? srcfg_pkg::SQ_PTR2 : srcfg_pkg::SQ_IDLE;
               srcfg_pkg::SQ_SET2:
                  seq_r <= (wd == `SRCFG_PTR3) ? srcfg_pkg::SQ_PTR3 : srcfg_pkg::SQ_IDLE;
               srcfg_pkg::SQ_VAL1:
                  seq_r <= (wd == `SRCFG_PTR4) ? srcfg_pkg::SQ_PTR4 : srcfg_pkg::SQ_IDLE;
               default:
                  seq_r <= (wd == `SRCFG_PTR1
                            && mode_r[`SRCFG_F_MODE] == `SRCFG_MODE_STANDBY
                            && pm_ok(pwr_r[`SRCFG_F_PM_WAKE]))
                           ? srcfg_pkg::SQ_PTR1 : srcfg_pkg::SQ_IDLE;
            endcase
         end
      end else if (wr_aux) begin
         case (seq_r)
            srcfg_pkg::SQ_PTR1:
               seq_r <= (wd == `SRCFG_SET1) ? srcfg_pkg::SQ_SET1 : srcfg_pkg::SQ_IDLE;
            srcfg_pkg::SQ_PTR2:
               seq_r <= (wd == `SRCFG_SET2) ? srcfg_pkg::SQ_SET2 : srcfg_pkg::SQ_IDLE;
            srcfg_pkg::SQ_PTR3:
               seq_r <= (wd == val1(pwr_r[`SRCFG_F_PM_WAKE]))
                        ? srcfg_pkg::SQ_VAL1 : srcfg_pkg::SQ_IDLE;
            srcfg_pkg::SQ_PTR4:
               seq_r <= (wd == val2(pwr_r[`SRCFG_F_PM_WAKE]))
                        ? srcfg_pkg::SQ_ARMED : srcfg_pkg::SQ_IDLE;
            default:
               seq_r <= srcfg_pkg::SQ_IDLE;
         endcase
      end else if (wr_mode || wr_pwr || wr_act) begin
         seq_r <= srcfg_pkg::SQ_IDLE;
      end
   end

   // hidden settings follow the power mode they were written for
   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         unlock_r <= 1'b0;
      end else if (wr_wake && wd == `SRCFG_RATE15 && seq_r == srcfg_pkg::SQ_ARMED) begin
         unlock_r <= 1'b1;
      end else if (wr_pwr || (wr_wake && wd == `SRCFG_PTR1)) begin
         unlock_r <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // effective rates and mode outputs
   // ----------------------------------------------------------------
   srcfg_odr_lut #(.IS_ACT(0)) u_wake_lut (
      .code(wake_code_r),
      .pmode(pwr_r[`SRCFG_F_PM_WAKE]),
      .rate(wake_lut)
   );

   srcfg_odr_lut #(.IS_ACT(1)) u_act_lut (
      .code(act_code_r),
      .pmode(pwr_r[`SRCFG_F_PM_ACT]),
      .rate(act_lut)
   );

   assign wake_ok = wake_lut.ok && (wake_code_r != `SRCFG_RATE15 || unlock_r);

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         wake_odr_r <= 16'h0;
         wake_ok_r <= 1'b0;
         act_odr_r <= 16'h0;
         act_ok_r <= 1'b0;
      end else begin
         wake_odr_r <= wake_ok ? wake_lut.odr : 16'h0;
         wake_ok_r <= wake_ok;
         act_odr_r <= act_lut.odr;
         act_ok_r <= act_lut.ok;
      end
   end

   always_ff @(posedge REF_CLK or negedge RSTN) begin
      if (!RSTN) begin
         continuous_wake_r <= 1'b0;
         stby_r <= 1'b0;
         stby_clk_r <= 3'h0;
      end else begin
         continuous_wake_r <= mode_r[`SRCFG_F_MODE] == `SRCFG_MODE_CONTINUOUS_WAKE;
         stby_r <= mode_r[`SRCFG_F_MODE] == `SRCFG_MODE_STANDBY;
         stby_clk_r <= act_stby_r;
      end
   end

   assign HRDATA = hrdata_r;
   assign HREADYOUT = hready_r;
   assign HRESP = hresp_r;
   assign WAKE_ODR = wake_odr_r;
   assign WAKE_ODR_OK = wake_ok_r;
   assign ACT_ODR = act_odr_r;
   assign ACT_ODR_OK = act_ok_r;
   assign STBY_CLK_CODE = stby_clk_r;
   assign CONT_WAKE = continuous_wake_r;
   assign STANDBY = stby_r;
   assign RATE15_UNLOCKED = unlock_r;

   // ----------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------
   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (!RSTN);

   sequence s_val2_ok;
      wr_aux && seq_r == srcfg_pkg::SQ_PTR4 && wd == val2(pwr_r[`SRCFG_F_PM_WAKE]);
   endsequence
   sequence s_apply;
      wr_wake && wd == `SRCFG_RATE15 && seq_r == srcfg_pkg::SQ_ARMED;
   endsequence

   property p_wake_upper_zero;
      (rd_pend_r && hit(req_r.addr, `SRCFG_IDX_WAKE)) |=> HRDATA[7:4] == 4'h0 && HREADYOUT;
   endproperty
   a_wake_upper_zero: assert property (p_wake_upper_zero) else $error("wake upper bits set");

   property p_wake_ulp_25;
      (wake_code_r == 4'h6 && pwr_r[`SRCFG_F_PM_WAKE] == `SRCFG_PM_ULP)
         |=> WAKE_ODR == 16'h00fa && WAKE_ODR_OK;
   endproperty
   a_wake_ulp_25: assert property (p_wake_ulp_25) else $error("wake 25 Hz not reported");

   property p_wake_bad_pm;
      !pm_ok(pwr_r[`SRCFG_F_PM_WAKE]) |=> !WAKE_ODR_OK && WAKE_ODR == 16'h0;
   endproperty
   a_wake_bad_pm: assert property (p_wake_bad_pm) else $error("bad power mode gave rate");

   property p_act_lp_28;
      (act_code_r == 4'h6 && pwr_r[`SRCFG_F_PM_ACT] == `SRCFG_PM_LP && pwr_r[2:0] != 3'h0)
         |=> ACT_ODR == 16'h0118;
   endproperty
   a_act_lp_28: assert property (p_act_lp_28) else $error("activity mode bits wrong");

   property p_act_high_code;
      act_code_r > 4'hb |=> !ACT_ODR_OK;
   endproperty
   a_act_high_code: assert property (p_act_high_code) else $error("activity code over 1011 ok");

   property p_mode_out;
      mode_r[`SRCFG_F_MODE] == `SRCFG_MODE_CONTINUOUS_WAKE |=> CONT_WAKE && !STANDBY;
   endproperty
   a_mode_out: assert property (p_mode_out) else $error("continuous wake not shown");

   property p_apply;
      s_apply |=> RATE15_UNLOCKED ##1 WAKE_ODR_OK && WAKE_ODR != 16'h0;
   endproperty
   a_apply: assert property (p_apply) else $error("rate 15 not applied");

   property p_arm;
      s_val2_ok |=> seq_r == srcfg_pkg::SQ_ARMED;
   endproperty
   a_arm: assert property (p_arm) else $error("sequence not armed");

   property p_locked_f;
      (wake_code_r == 4'hf && !unlock_r) |=> !WAKE_ODR_OK;
   endproperty
   a_locked_f: assert property (p_locked_f) else $error("rate 15 used while locked");

   property p_accept_any;
      (wr_wake && wd == 8'h0d) |=> wake_code_r == 4'hd && !HRESP;
   endproperty
   a_accept_any: assert property (p_accept_any) else $error("unsupported code refused");

   property p_act_rsv;
      (rd_pend_r && hit(req_r.addr, `SRCFG_IDX_ACT)) |=> !HRDATA[`SRCFG_B_ACT_RSV];
   endproperty
   a_act_rsv: assert property (p_act_rsv) else $error("activity bit 4 read set");
endmodule // srcfg_sample_rate_config
`default_nettype wire

// file: test/srcfg_host_model.sv
/*
 * host model: single-word AHB-Lite master that reaches the rate registers.
 * assumes: one slave whose HREADYOUT is looped back as HREADY.
 */
`timescale 1ns/10ps
`default_nettype none
module srcfg_host_model (
   // clock
   input wire logic clk,
   // AHB-Lite master
   output logic hsel,
   output logic [31:0] haddr,
   output logic [1:0] htrans,
   output logic hwrite,
   output logic [2:0] hsize,
   output logic [31:0] hwdata,
   input wire logic hready,
   input wire logic [31:0] hrdata
);
   initial begin
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hsize = 3'h2;
      hwdata = 32'h0;
   end

   // one word transfer; address and data held until hready is sampled high
   task automatic xfer(input logic wr, input logic [7:0] idx, input logic [31:0] wd,
                       output logic [31:0] rd);
      @(posedge clk);
      hsel <= 1'b1;
      htrans <= 2'h2;
      hwrite <= wr;
      haddr <= {22'h0, idx, 2'h0};
      do @(posedge clk); while (hready !== 1'b1);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= wd;
      do @(posedge clk); while (hready !== 1'b1);
      rd = hrdata;
      // released lines must not keep showing the old value
      hwdata <= ~wd;
      haddr <= ~haddr;
   endtask
endmodule // srcfg_host_model
`default_nettype wire

// file: test/test_srcfg_sample_rate_config.sv
/*
 * testbench of the sample rate configuration block: register access,
 * wake and activity rate lookup, rate 15 unlock sequence.
 * assumes: host model drives the bus; HREADY looped from HREADYOUT.
 */
`timescale 1ns/10ps
`default_nettype none
`include "srcfg_params.svh"
module test_srcfg_sample_rate_config;
   logic ref_clk, rstn, hsel, hwrite, hready, hresp;
   logic [31:0] haddr, hwdata, hrdata;
   logic [1:0] htrans;
   logic [2:0] hsize, stby;
   logic [15:0] wake_odr, act_odr;
   logic wake_ok, act_ok, cont_wake, standby, unlocked;
   int n_fail = 0;
   int n_checks = 0;
   // expected rates in tenths of a hertz, power register writes and unlock values
   logic [15:0] ulp_w [8] = '{16'h0, 16'h00fa, 16'h01f4, 16'h03e8, 16'h076c, 16'h0ed8,
                              16'h1d4c, 16'h2af8};
   logic [15:0] ulp_a [13] = '{16'h3c, 16'h4, 16'h8, 16'hf, 16'h3c, 16'h82, 16'hfa,
                               16'h1f4, 16'h3e8, 16'h76c, 16'hed8, 16'h1d4c, 16'h0};
   logic [7:0] pw [3] = '{8'h03, 8'h00, 8'h04};
   logic [7:0] v1 [3] = '{8'h52, 8'h72, 8'h32};
   logic [7:0] v2 [3] = '{8'h01, 8'h02, 8'h12};
   logic [15:0] r8 [3] = '{16'h03e8, 16'h041a, 16'h0320};
   logic [15:0] r15 [3] = '{16'h32c8, 16'h1d4c, 16'h03e8};

   srcfg_host_model host (.clk(ref_clk), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata));

   srcfg_sample_rate_config dut (.REF_CLK(ref_clk), .RSTN(rstn), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
      .WAKE_ODR(wake_odr), .WAKE_ODR_OK(wake_ok), .ACT_ODR(act_odr), .ACT_ODR_OK(act_ok),
      .STBY_CLK_CODE(stby), .CONT_WAKE(cont_wake), .STANDBY(standby),
      .RATE15_UNLOCKED(unlocked));

   // ----------------------------------------------------------------
   // compares and bus tasks
   // ----------------------------------------------------------------
   task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_rate(input logic ok, input logic [15:0] odr, input logic eok,
                           input logic [15:0] eodr);
      n_checks++;
      if (ok !== eok || odr !== eodr) begin
         n_fail++;
         $display("[ERR] %0t rate %b/%h expected %b/%h", $time, ok, odr, eok, eodr);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t flag %b expected %b", $time, got, exp);
      end
   endtask

   // write, then let the one-edge output lag pass
   task automatic wr(input logic [7:0] idx, input logic [7:0] d);
      logic [31:0] rd;
      host.xfer(1'b1, idx, {24'h0, d}, rd);
      repeat (3) @(posedge ref_clk);
   endtask

   task automatic rdchk(input logic [7:0] idx, input logic [31:0] exp);
      logic [31:0] rd;
      host.xfer(1'b0, idx, 32'h0, rd);
      chk_reg(rd, exp);
   endtask

   task automatic done(input string name);
      $display("test %s done, %0d checks", name, n_checks);
   endtask

   task automatic unlock(input logic [7:0] p, input logic [7:0] s1, input logic [7:0] a,
                         input logic [7:0] b);
      wr(`SRCFG_IDX_MODE, 8'h01);
      chk_bit(standby, 1'b1);
      wr(`SRCFG_IDX_PWR, p);
      chk_bit(unlocked, 1'b0);
      wr(`SRCFG_IDX_WAKE, 8'h10);
      wr(`SRCFG_IDX_AUX, s1);
      wr(`SRCFG_IDX_WAKE, 8'h20);
      wr(`SRCFG_IDX_AUX, 8'h01);
      wr(`SRCFG_IDX_WAKE, 8'h40);
      wr(`SRCFG_IDX_AUX, a);
      wr(`SRCFG_IDX_WAKE, 8'h50);
      wr(`SRCFG_IDX_AUX, b);
      wr(`SRCFG_IDX_WAKE, 8'h0f);
      wr(`SRCFG_IDX_MODE, 8'h05);
      chk_bit(cont_wake, 1'b1);
      chk_bit(standby, 1'b0);
   endtask

   task automatic print_verdict();
      $display("checks %0d, mismatches %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // clock, watchdog, tests
   // ----------------------------------------------------------------
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end

   initial begin
      #200000;
      n_fail++;
      $display("[ERR] %0t watchdog expired", $time);
      print_verdict();
   end

   initial begin
      rstn = 1'b0;
      repeat (6) @(posedge ref_clk);
      rstn <= 1'b1;
      @(posedge ref_clk);
      rdchk(`SRCFG_IDX_WAKE, 32'h0);
      rdchk(`SRCFG_IDX_ACT, 32'h0);
      chk_rate(wake_ok, wake_odr, 1'b0, 16'h0);
      chk_rate(act_ok, act_odr, 1'b1, 16'h0046);
      chk_bit(hresp, 1'b0);
      done("reset");
      wr(`SRCFG_IDX_PWR, 8'h03);
      for (int i = 0; i < 8; i++) begin
         wr(`SRCFG_IDX_WAKE, 8'h05 + 8'(i));
         chk_rate(wake_ok, wake_odr, ulp_w[i] != 16'h0, ulp_w[i]);
      end
      rdchk(`SRCFG_IDX_WAKE, 32'h0c);
      wr(`SRCFG_IDX_WAKE, 8'h0f);
      chk_rate(wake_ok, wake_odr, 1'b0, 16'h0);
      wr(`SRCFG_IDX_WAKE, 8'h08);
      for (int i = 0; i < 3; i++) begin
         wr(`SRCFG_IDX_PWR, pw[i]);
         chk_rate(wake_ok, wake_odr, 1'b1, r8[i]);
      end
      wr(`SRCFG_IDX_WAKE, 8'h0d);
      chk_rate(wake_ok, wake_odr, 1'b0, 16'h0);
      rdchk(`SRCFG_IDX_WAKE, 32'h0d);
      wr(`SRCFG_IDX_WAKE, 8'h09);
      chk_rate(wake_ok, wake_odr, 1'b0, 16'h0);
      done("wake");
      wr(`SRCFG_IDX_PWR, 8'h30);
      for (int i = 0; i < 13; i++) begin
         wr(`SRCFG_IDX_ACT, {3'h5, 1'b0, 4'(i)});
         chk_rate(act_ok, act_odr, ulp_a[i] != 16'h0, ulp_a[i]);
      end
      chk_reg({29'h0, stby}, 32'h5);
      rdchk(`SRCFG_IDX_ACT, 32'hac);
      wr(`SRCFG_IDX_PWR, 8'h03);
      wr(`SRCFG_IDX_ACT, 8'h06);
      chk_rate(act_ok, act_odr, 1'b1, 16'h0118);
      wr(`SRCFG_IDX_ACT, 8'h00);
      wr(`SRCFG_IDX_PWR, 8'h03);
      chk_rate(act_ok, act_odr, 1'b1, 16'h0046);
      done("activity");
      for (int i = 0; i < 3; i++) begin
         unlock(pw[i], 8'h03, v1[i], v2[i]);
         chk_bit(unlocked, 1'b1);
         chk_rate(wake_ok, wake_odr, 1'b1, r15[i]);
      end
      rdchk(`SRCFG_IDX_STAT, 32'h7);
      rdchk(`SRCFG_IDX_ODR, 32'h004603e8);
      wr(`SRCFG_IDX_ODR, 8'hff);
      rdchk(`SRCFG_IDX_ODR, 32'h004603e8);
      wr(8'hff, 8'h5a);
      rdchk(8'hff, 32'h0);
      unlock(8'h03, 8'h04, 8'h52, 8'h01);
      chk_bit(unlocked, 1'b0);
      chk_rate(wake_ok, wake_odr, 1'b0, 16'h0);
      wr(`SRCFG_IDX_MODE, 8'h02);
      chk_bit(standby, 1'b0);
      chk_bit(cont_wake, 1'b0);
      done("unlock");
      print_verdict();
   end
endmodule // test_srcfg_sample_rate_config
`default_nettype wire
